/* File: logic/pegp_port.sv */
// The APB register port and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - port pin with direction bit 1 drives out, 0 is input.
// - 16-bit bus in modes 4-6 ignores direction bits, pins join data bus.
// - in 16-bit bus mode pin n is bidirectional data line n.
// - eight-bit output data register, read/write, resets to zero.
// - pin read gives data bit if direction 1, else live pin level.
// - eight-bit pull-up control register, resets zero, 1 requests pull-up.
// - pull-ups usable only in 8-bit modes 4-6 or mode 7, per bit; here usable in every mode except full-variant 16-bit modes 4-6.
// - pull-up on exactly when direction 0 and pull-up bit 1.
// - pull-ups forced off for bus lines and for output pins always.
// - reduced variant pins are plain I/O, direction bit only, no bus.
// - direction bits write-only, reset to zero, so pins start as inputs.
module pegp_port
    import pegp_pkg::*;
#(
    parameter int WIDTH = PEGP_WIDTH
) (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire pegp_pkg::pegp_addr_t paddr_i,
    input wire pegp_pkg::pegp_word_t pwdata_i,
    input wire logic [3:0] pstrb_i,
    output logic pready_o,
    output pegp_pkg::pegp_word_t prdata_o,
    output logic pslverr_o,
    input wire logic [2:0] op_mode_i,
    input wire logic bus16_i,
    input wire logic reduced_variant_i,
    input wire pegp_pkg::pegp_byte_t bus_dout_i,
    input wire logic bus_drive_i,
    output pegp_pkg::pegp_byte_t bus_din_o,
    input wire pegp_pkg::pegp_byte_t pin_in_i,
    output pegp_pkg::pegp_byte_t pin_out_o,
    output pegp_pkg::pegp_byte_t pin_oe_n_o,
    output pegp_pkg::pegp_byte_t pullup_en_o
);
    import pegp_pkg::*;

    if (WIDTH != PEGP_WIDTH) begin : g_width_check
        $error("pegp_port: only an eight-bit port is supported");
    end

    // the synchroniser is built with two flops only
    if (PEGP_SYNC_STAGES != 2) begin : g_sync_check
        $error("pegp_port: pin synchroniser has exactly two stages");
    end

    function automatic pegp_sel_e reg_sel(input pegp_addr_t a);
        unique case (a)
            PEGP_OFF_DIR: reg_sel = PEGP_SEL_DIR;
            PEGP_OFF_OUT: reg_sel = PEGP_SEL_OUT;
            PEGP_OFF_PIN: reg_sel = PEGP_SEL_PIN;
            PEGP_OFF_PULL: reg_sel = PEGP_SEL_PULL;
            default: reg_sel = PEGP_SEL_NONE;
        endcase
    endfunction

    pegp_cfg_s cfg_ff;
    pegp_cfg_s nxt_cfg;
    pegp_pad_s pad_ff;
    pegp_pad_s nxt_pad;
    pegp_byte_t pin_sync;
    pegp_byte_t pin_view;
    logic pready_ff;
    logic pslverr_ff;
    pegp_word_t prdata_ff;
    pegp_byte_t bus_din_ff;
    logic bus_owned;
    logic access;
    logic wr_done;
    pegp_sel_e sel;

    pegp_sync #(
        .WIDTH(WIDTH)
    ) u_pin_sync (
        .clk_i(clk_i),
        .sys_rst_i(sys_rst_i),
        .d_i(pin_in_i),
        .q_o(pin_sync)
    );

    // bus owns the pins only in 16-bit modes 4-6 on the full variant
    assign bus_owned = !reduced_variant_i && bus16_i && (op_mode_i >= PEGP_MODE_EXT_LO)
        && (op_mode_i <= PEGP_MODE_EXT_HI);
    assign sel = reg_sel(paddr_i);
    assign access = psel_i && penable_i;
    // one wait state so every answer comes from a flop
    assign wr_done = access && pready_ff && pwrite_i && pstrb_i[0];

    // output data shows for outputs, synchronised level for inputs
    assign pin_view = (cfg_ff.dir & cfg_ff.out) | (~cfg_ff.dir & pin_sync);

    always_comb begin
        nxt_cfg = cfg_ff;
        if (wr_done) begin
            unique case (sel)
                PEGP_SEL_DIR: nxt_cfg.dir = pwdata_i[7:0];
                PEGP_SEL_OUT: nxt_cfg.out = pwdata_i[7:0];
                PEGP_SEL_PULL: nxt_cfg.pull = pwdata_i[7:0];
                PEGP_SEL_PIN, PEGP_SEL_NONE: nxt_cfg = cfg_ff;
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            cfg_ff.dir <= PEGP_RST_DIR;
            cfg_ff.out <= PEGP_RST_OUT;
            cfg_ff.pull <= PEGP_RST_PULL;
        end else begin
            cfg_ff <= nxt_cfg;
        end
    end

    // pads follow the next register values so a write shows one cycle on
    for (genvar n = 0; n < WIDTH; n++) begin : g_pin
        always_comb begin
            if (bus_owned) begin
                nxt_pad.out[n] = bus_dout_i[n];
                nxt_pad.oe_n[n] = !bus_drive_i;
                nxt_pad.pull[n] = 1'b0;
            end else begin
                nxt_pad.out[n] = nxt_cfg.out[n];
                nxt_pad.oe_n[n] = !nxt_cfg.dir[n];
                nxt_pad.pull[n] = !nxt_cfg.dir[n] && nxt_cfg.pull[n];
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            pad_ff.out <= PEGP_RST_OUT;
            pad_ff.oe_n <= 8'hff;
            pad_ff.pull <= 8'h00;
        end else begin
            pad_ff <= nxt_pad;
        end
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            bus_din_ff <= 8'h00;
        end else begin
            bus_din_ff <= pin_sync;
        end
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff <= '0;
        end else if (access && !pready_ff) begin
            pready_ff <= 1'b1;
            pslverr_ff <= (sel == PEGP_SEL_NONE);
            unique case (sel)
                PEGP_SEL_OUT: prdata_ff <= {24'h000000, cfg_ff.out};
                PEGP_SEL_PIN: prdata_ff <= {24'h000000, pin_view};
                PEGP_SEL_PULL: prdata_ff <= {24'h000000, cfg_ff.pull};
                // direction is write-only and reads as zero
                PEGP_SEL_DIR, PEGP_SEL_NONE: prdata_ff <= '0;
            endcase
        end else begin
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff <= '0;
        end
    end

    assign pready_o = pready_ff;
    assign pslverr_o = pslverr_ff;
    assign prdata_o = prdata_ff;
    assign bus_din_o = bus_din_ff;
    assign pin_out_o = pad_ff.out;
    assign pin_oe_n_o = pad_ff.oe_n;
    assign pullup_en_o = pad_ff.pull;

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (sys_rst_i);

    AST_PORT_DIR: assert property (
        !bus_owned |=> pin_oe_n_o == ~cfg_ff.dir
    ) else $error("port pin direction does not follow direction bit");

    AST_BUS_DIR: assert property (
        bus_owned |=> pin_oe_n_o == {8{!$past(bus_drive_i)}}
    ) else $error("bus mode pin enables not all following bus drive");

    AST_BUS_DATA: assert property (
        bus_owned |=> pin_out_o == $past(bus_dout_i)
    ) else $error("bus mode pin data not taken from data bus");

    AST_OUT_WRITE: assert property (
        wr_done && sel == PEGP_SEL_OUT |=> cfg_ff.out == $past(pwdata_i[7:0])
    ) else $error("output data register write lost");

    AST_PIN_READ: assert property (
        access && !pready_ff && sel == PEGP_SEL_PIN
        |=> pready_o && prdata_o[7:0] == $past(pin_view) && prdata_o[31:8] == 24'h000000
    ) else $error("pin register read wrong value");

    AST_PULL_RULE: assert property (
        !bus_owned |=> pullup_en_o == (~cfg_ff.dir & cfg_ff.pull)
    ) else $error("pull-up enable differs from direction and control");

    AST_PULL_OFF: assert property (
        (pullup_en_o & ~pin_oe_n_o) == 8'h00 && !($past(bus_owned) && pullup_en_o != 8'h00)
    ) else $error("pull-up on for a driven or bus pin");

    AST_DIR_RESET: assert property (
        $past(sys_rst_i) |-> cfg_ff.dir == 8'h00 && pin_oe_n_o == 8'hff
    ) else $error("direction not cleared by reset");

    AST_WRITE_LATENCY: assert property (
        wr_done && sel == PEGP_SEL_DIR && !bus_owned
        |=> pin_oe_n_o == ~$past(pwdata_i[7:0])
    ) else $error("direction write not on pins next cycle");

    AST_APB_ONE_WAIT: assert property (
        access && !pready_ff |=> pready_o ##1 !pready_o
    ) else $error("apb answer not after exactly one wait");

    // reset values reach the pads as well as the registers
    AST_OUT_RESET: assert property (
        $past(sys_rst_i)
        |-> cfg_ff.out == 8'h00 && pin_out_o == 8'h00
    ) else $error("output data not cleared by reset");

    AST_PULL_RESET: assert property (
        $past(sys_rst_i)
        |-> cfg_ff.pull == 8'h00 && pullup_en_o == 8'h00
    ) else $error("pull-up control not cleared by reset");

    AST_PORT_DATA: assert property (
        !bus_owned
        |=> pin_out_o == cfg_ff.out
    ) else $error("port pin data does not follow output register");

    AST_BUS_NO_PULL: assert property (
        bus_owned
        |=> pullup_en_o == 8'h00
    ) else $error("pull-up on while pins belong to the data bus");

    // a one-edge reset leaves the sampled sync value unknown, so skip that edge
    AST_BUS_DIN: assert property (
        !$past(sys_rst_i)
        |-> bus_din_o == $past(pin_sync)
    ) else $error("bus input data not one cycle behind synchronised pins");

    AST_SINGLE_PORT: assert property (
        op_mode_i == PEGP_MODE_SINGLE
        |=> pin_oe_n_o == ~cfg_ff.dir && pullup_en_o == (~cfg_ff.dir & cfg_ff.pull)
    ) else $error("single-chip mode pin not under port control");

    AST_REDUCED_PORT: assert property (
        reduced_variant_i
        |=> pin_oe_n_o == ~cfg_ff.dir && pin_out_o == cfg_ff.out
    ) else $error("reduced variant pin not a plain port pin");

    AST_DIR_WRITE: assert property (
        wr_done && sel == PEGP_SEL_DIR
        |=> cfg_ff.dir == $past(pwdata_i[7:0])
    ) else $error("direction register write lost");

    AST_PULL_WRITE: assert property (
        wr_done && sel == PEGP_SEL_PULL
        |=> cfg_ff.pull == $past(pwdata_i[7:0])
    ) else $error("pull-up control register write lost");

    AST_PULL_LATENCY: assert property (
        wr_done && sel == PEGP_SEL_PULL && !bus_owned
        |=> pullup_en_o == (~cfg_ff.dir & $past(pwdata_i[7:0]))
    ) else $error("pull-up write not on pins next cycle");

    // strobe bit 0 guards the only byte lane that holds data
    AST_STRB_IGNORED: assert property (
        access && pready_ff && pwrite_i && !pstrb_i[0]
        |=> $stable(cfg_ff)
    ) else $error("write with low strobe changed a register");

    AST_DIR_READ_ZERO: assert property (
        access && !pready_ff && sel == PEGP_SEL_DIR
        |=> pready_o && prdata_o == '0 && !pslverr_o
    ) else $error("write-only direction register did not read zero");

    AST_OUT_READ: assert property (
        access && !pready_ff && sel == PEGP_SEL_OUT
        |=> prdata_o[7:0] == $past(cfg_ff.out) && prdata_o[31:8] == 24'h000000
    ) else $error("output data register read wrong value");

    AST_PULL_READ: assert property (
        access && !pready_ff && sel == PEGP_SEL_PULL
        |=> prdata_o[7:0] == $past(cfg_ff.pull) && prdata_o[31:8] == 24'h000000
    ) else $error("pull-up control register read wrong value");

    AST_BAD_ADDR: assert property (
        access && !pready_ff
        |=> pslverr_o == ($past(sel) == PEGP_SEL_NONE)
    ) else $error("slave error does not match address decode");

    // answers stand only with ready so stale data never leaks
    AST_IDLE_QUIET: assert property (
        !pready_o
        |-> prdata_o == '0 && !pslverr_o
    ) else $error("read data or error outside the answer cycle");

    COV_BUS16: cover property (bus_owned && bus_drive_i ##1 pin_oe_n_o == 8'h00);
    COV_PULL_ON: cover property (!bus_owned ##1 pullup_en_o != 8'h00);
    COV_PIN_READ: cover property (pready_o && sel == PEGP_SEL_PIN && !pwrite_i);
    COV_BAD_ADDR: cover property (pready_o && pslverr_o);
    COV_REDUCED_PULL: cover property (reduced_variant_i && bus16_i ##1 pullup_en_o != 8'h00);
endmodule
`default_nettype wire

/* File: shared/pegp_pkg.sv */
package pegp_pkg;
    localparam int PEGP_WIDTH = 8;
    localparam int PEGP_ADDR_W = 12;
    localparam int PEGP_DATA_W = 32;

    typedef logic [PEGP_WIDTH-1:0] pegp_byte_t;
    typedef logic [PEGP_ADDR_W-1:0] pegp_addr_t;
    typedef logic [PEGP_DATA_W-1:0] pegp_word_t;

    // register byte offsets
    localparam pegp_addr_t PEGP_OFF_DIR = 12'h000;
    localparam pegp_addr_t PEGP_OFF_OUT = 12'h004;
    localparam pegp_addr_t PEGP_OFF_PIN = 12'h008;
    localparam pegp_addr_t PEGP_OFF_PULL = 12'h00c;

    // reset values
    localparam pegp_byte_t PEGP_RST_DIR = 8'h00;
    localparam pegp_byte_t PEGP_RST_OUT = 8'h00;
    localparam pegp_byte_t PEGP_RST_PULL = 8'h00;

    // operating mode codes
    localparam logic [2:0] PEGP_MODE_EXT_LO = 3'h4;
    localparam logic [2:0] PEGP_MODE_EXT_HI = 3'h6;
    localparam logic [2:0] PEGP_MODE_SINGLE = 3'h7;

    // synchroniser depth on pin inputs
    localparam int PEGP_SYNC_STAGES = 2;

    typedef enum logic [2:0] {
        PEGP_SEL_NONE,
        PEGP_SEL_DIR,
        PEGP_SEL_OUT,
        PEGP_SEL_PIN,
        PEGP_SEL_PULL
    } pegp_sel_e;

    typedef struct packed {
        pegp_byte_t dir;
        pegp_byte_t out;
        pegp_byte_t pull;
    } pegp_cfg_s;

    typedef struct packed {
        pegp_byte_t out;
        pegp_byte_t oe_n;
        pegp_byte_t pull;
    } pegp_pad_s;
endpackage

/* File: logic/pegp_sync.sv */
`timescale 1ns/1ps
`default_nettype none
module pegp_sync #(
    parameter int WIDTH = 8
) (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic [WIDTH-1:0] d_i,
    output logic [WIDTH-1:0] q_o
);
    logic [WIDTH-1:0] meta_ff;
    logic [WIDTH-1:0] sync_ff;

    // first stage feeds only the second
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            meta_ff <= '0;
            sync_ff <= '0;
        end else begin
            meta_ff <= d_i;
            sync_ff <= meta_ff;
        end
    end

    assign q_o = sync_ff;
endmodule
`default_nettype wire

/* File: sim/pegp_pins.sv */
`timescale 1ns/1ps
`default_nettype none
module pegp_pins
    import pegp_pkg::*;
(
    input wire pegp_pkg::pegp_byte_t out_i,
    input wire pegp_pkg::pegp_byte_t oe_n_i,
    input wire pegp_pkg::pegp_byte_t pull_i,
    input wire pegp_pkg::pegp_byte_t ext_en_i,
    input wire pegp_pkg::pegp_byte_t ext_val_i,
    output pegp_pkg::pegp_byte_t lvl_o
);
    // undriven, unpulled pin floats: show inverse so a stale value never passes
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            if (!oe_n_i[i]) lvl_o[i] = out_i[i];
            else if (ext_en_i[i]) lvl_o[i] = ext_val_i[i];
            else if (pull_i[i]) lvl_o[i] = 1'b1;
            else lvl_o[i] = ~out_i[i];
        end
    end
endmodule
`default_nettype wire

/* File: sim/testbench.sv */
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import pegp_pkg::*;
    logic clk_i, rst, psel, pen, pwr, pready, perr, b16, red, bdrv;
    pegp_addr_t paddr;
    pegp_word_t pwdata, prdata, r;
    logic [3:0] pstrb;
    logic [2:0] mode;
    pegp_byte_t bdo, bdin, lvl, pout, poe_n, pup, xen, xval;
    int failures = 0;
    int checked = 0;
    pegp_port dut (.clk_i(clk_i), .sys_rst_i(rst), .psel_i(psel), .penable_i(pen),
        .pwrite_i(pwr), .paddr_i(paddr), .pwdata_i(pwdata), .pstrb_i(pstrb),
        .pready_o(pready), .prdata_o(prdata), .pslverr_o(perr), .op_mode_i(mode),
        .bus16_i(b16), .reduced_variant_i(red), .bus_dout_i(bdo), .bus_drive_i(bdrv),
        .bus_din_o(bdin), .pin_in_i(lvl), .pin_out_o(pout), .pin_oe_n_o(poe_n),
        .pullup_en_o(pup));
    pegp_pins pins (.out_i(pout), .oe_n_i(poe_n), .pull_i(pup), .ext_en_i(xen),
        .ext_val_i(xval), .lvl_o(lvl));
    initial begin
        clk_i = 1'b0;
        forever #20 clk_i = ~clk_i;
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            failures++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic report_and_stop;
        $display("checked=%0d failures=%0d", checked, failures);
        if (failures == 0 && checked > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    // hold the request until pready is seen, then release right after that edge
    task automatic apb(input logic w, input pegp_addr_t a, input pegp_word_t d,
        input logic [3:0] s, output logic e);
        int n;
        n = 0;
        @(posedge clk_i);
        psel <= 1'b1; pwr <= w; paddr <= a; pwdata <= d; pstrb <= s;
        @(posedge clk_i);
        pen <= 1'b1;
        do begin
            @(posedge clk_i);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) failures++;
        r = prdata;
        e = perr;
        psel <= 1'b0; pen <= 1'b0;
    endtask
    task automatic wr(input pegp_addr_t a, input pegp_byte_t d);
        logic e;
        apb(1'b1, a, {24'h0, d}, 4'hf, e);
    endtask
    task automatic rd(input pegp_addr_t a, input pegp_byte_t exp);
        logic e;
        apb(1'b0, a, 32'h0, 4'h0, e);
        chk(r, {24'h0, exp});
    endtask
    task automatic pads(input pegp_byte_t o, input pegp_byte_t oe_n, input pegp_byte_t pu);
        repeat (6) @(negedge clk_i);
        chk({8'h0, pout, poe_n, pup}, {8'h0, o, oe_n, pu});
    endtask
    task automatic setm(input logic [2:0] m, input logic w16, input logic rv);
        @(posedge clk_i);
        mode <= m; b16 <= w16; red <= rv;
    endtask
    initial begin
        logic e;
        rst = 1'b1; psel = 1'b0; pen = 1'b0; pwr = 1'b0; paddr = '0; pwdata = '0;
        pstrb = '0; mode = 3'h7; b16 = 1'b0; red = 1'b0; bdo = '0; bdrv = 1'b0;
        xen = 8'hff; xval = 8'h3c;
        repeat (6) @(posedge clk_i);
        rst <= 1'b0;
        pads(8'h00, 8'hff, 8'h00);
        rd(PEGP_OFF_OUT, 8'h00);
        rd(PEGP_OFF_PULL, 8'h00);
        $display("test reset done");
        wr(PEGP_OFF_DIR, 8'h0f);
        wr(PEGP_OFF_OUT, 8'ha5);
        pads(8'ha5, 8'hf0, 8'h00);
        rd(PEGP_OFF_PIN, 8'h35);
        rd(PEGP_OFF_DIR, 8'h00);
        $display("test port mode done");
        xen <= 8'h00;
        wr(PEGP_OFF_PULL, 8'hff);
        pads(8'ha5, 8'hf0, 8'hf0);
        rd(PEGP_OFF_PIN, 8'hf5);
        setm(3'h5, 1'b0, 1'b0);
        pads(8'ha5, 8'hf0, 8'hf0);
        setm(3'h7, 1'b1, 1'b0);
        pads(8'ha5, 8'hf0, 8'hf0);
        $display("test pull-up done");
        @(posedge clk_i);
        bdo <= 8'hc3; bdrv <= 1'b1;
        setm(3'h5, 1'b1, 1'b0);
        pads(8'hc3, 8'h00, 8'h00);
        @(posedge clk_i);
        bdrv <= 1'b0; xen <= 8'hff; xval <= 8'h96;
        pads(8'hc3, 8'hff, 8'h00);
        chk({24'h0, bdin}, 32'h96);
        setm(3'h6, 1'b1, 1'b0);
        pads(8'hc3, 8'hff, 8'h00);
        setm(3'h4, 1'b1, 1'b0);
        pads(8'hc3, 8'hff, 8'h00);
        setm(3'h5, 1'b1, 1'b1);
        pads(8'ha5, 8'hf0, 8'hf0);
        setm(3'h3, 1'b1, 1'b0);
        pads(8'ha5, 8'hf0, 8'hf0);
        $display("test bus mode done");
        apb(1'b0, 12'h010, 32'h0, 4'h0, e);
        chk({e, r[30:0]}, 32'h80000000);
        apb(1'b1, PEGP_OFF_OUT, 32'h5a, 4'h0, e);
        rd(PEGP_OFF_OUT, 8'ha5);
        $display("test refusals done");
        rst <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst <= 1'b0;
        pads(8'h00, 8'hff, 8'h00);
        rd(PEGP_OFF_OUT, 8'h00);
        rd(PEGP_OFF_PULL, 8'h00);
        $display("test second reset done");
        report_and_stop;
    end
    initial begin
        repeat (5000) @(posedge clk_i);
        failures++;
        report_and_stop;
    end
endmodule
`default_nettype wire
